// ---- pkg/lmr_pkg.sv ----
`default_nettype none
package lmr_pkg;
	// =========================================================
	// Link geometry
	localparam int LANES     = 4;
	localparam int LANE_W    = $clog2(LANES);
	localparam int ADDR_W    = 10 + LANE_W;
	localparam int DATA_W    = 32;
	localparam int ADDR_MSB  = ADDR_W - 1;

	// =========================================================
	// Soft register space (word addresses, top address bit 0)
	localparam logic [ADDR_W-2:0] CTRL_ADDR   = 11'h000;
	localparam logic [ADDR_W-2:0] STATUS_ADDR = 11'h001;
	localparam int CTRL_PHY_RST_BIT  = 0;
	localparam int CTRL_LOOPBACK_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam int ST_DONE_BIT    = 0;
	localparam int ST_LINK_BIT    = 1;
	localparam int ST_PLL_RST_BIT = 2;
	localparam int ST_PHY_RST_BIT = 3;
	localparam logic [DATA_W-1:0] RECFG_RESET = 32'h0000_0000;

	// =========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int PLL_LOCK_NS   = 1000;
	localparam int PHY_RESET_NS  = 1000;
	localparam int CNT_W         = 8;
	localparam logic [CNT_W-1:0] PLL_CYC =
		CNT_W'((PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] PHY_CYC =
		CNT_W'((PHY_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// =========================================================
	// Reset sequence states
	// Bit 0 holds the PLL in reset, bit 1 the PHY, so both reset
	// outputs are plain state flops with no decode glitch
	typedef enum logic [1:0] {
		SEQ_PLL  = 2'b11,
		SEQ_PHY  = 2'b10,
		SEQ_DONE = 2'b00
	} lmr_seq_t;
endpackage
`default_nettype wire

// ---- pkg/lmr_seq_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface lmr_seq_if;
	logic restart;
	logic std_mode;
	logic pll_reset;
	logic phy_reset;
	logic done;
	modport seq (input restart, input std_mode,
		output pll_reset, output phy_reset, output done);
	modport ctl (output restart, output std_mode,
		input pll_reset, input phy_reset, input done);
endinterface
`default_nettype wire

// ---- src/lmr_reset_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
module lmr_reset_seq (
	// Clock and reset
	input  wire logic mclk_i,
	input  wire logic rstn_i,
	// Control
	lmr_seq_if.seq    sq
);
	// =========================================================
	// Sequencer
	lmr_pkg::lmr_seq_t         state_reg, state_next;
	logic [lmr_pkg::CNT_W-1:0] cnt_reg, cnt_next;

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		if (sq.restart) begin
			// PLL held only when the core makes the user clock
			state_next = sq.std_mode ? lmr_pkg::SEQ_PLL : lmr_pkg::SEQ_PHY;
			cnt_next   = sq.std_mode ? lmr_pkg::PLL_CYC : lmr_pkg::PHY_CYC;
		end else begin
			case (state_reg)
				lmr_pkg::SEQ_PLL: begin
					if (cnt_reg == 8'h01) begin
						state_next = lmr_pkg::SEQ_PHY;
						cnt_next   = lmr_pkg::PHY_CYC;
					end else begin
						cnt_next = cnt_reg - 8'h01;
					end
				end
				lmr_pkg::SEQ_PHY: begin
					if (cnt_reg == 8'h01) begin
						state_next = lmr_pkg::SEQ_DONE;
					end else begin
						cnt_next = cnt_reg - 8'h01;
					end
				end
				default: begin
					state_next = lmr_pkg::SEQ_DONE;
				end
			endcase
		end
	end

	// Stepped by the management clock
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= lmr_pkg::SEQ_PLL;
			cnt_reg   <= lmr_pkg::PLL_CYC;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
		end
	end

	assign sq.pll_reset = state_reg[0];
	assign sq.phy_reset = state_reg[1];
	assign sq.done      = (state_reg == lmr_pkg::SEQ_DONE);
endmodule
`default_nettype wire

// ---- src/lmr_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Global management reset resets link logic, PLL (standard mode) and PHY.
// - Global reset is sampled on the management clock, active high, level.
// - Management clock runs register port, reconfiguration and reset sequencer.
// - Management address is 10 plus log2 of lane count bits wide.
// - Top address bit 1 selects reconfiguration, 0 selects soft registers.
// - Write is write strobe high with a 32-bit data word.
// - Read is read strobe high; 32-bit result returned on read data.
// - Wait-request high means request not taken; host holds it pending.
// - Core reset is asynchronous, active high, resets link layer only.
// - User clock driven by core in standard mode, by user otherwise.
// - Standard mode: user reset high during core reset until sequence done.
// - Link-up rises on user clock only after initialization completes.
// - One serial transmit output and receive input per lane.
module lmr_top (
	// Clock and reset
	input  wire logic                       mclk_i,
	input  wire logic                       rstn_i,
	input  wire logic                       mgmt_reset_i,
	input  wire logic                       core_reset_i,
	input  wire logic                       std_clk_mode_i,
	// Management port
	input  wire logic [lmr_pkg::ADDR_W-1:0] mgmt_port_addr_i,
	input  wire logic [lmr_pkg::DATA_W-1:0] mgmt_port_write_word_i,
	input  wire logic                       mgmt_port_write_i,
	input  wire logic                       mgmt_port_read_i,
	input  wire logic                       reconfig_busy_i,
	output logic      [lmr_pkg::DATA_W-1:0] mgmt_port_read_word_o,
	output logic                            mgmt_port_waitreq_o,
	// User side
	input  wire logic                       user_clock_i,
	output logic                            user_clock_o,
	output logic                            user_clock_oe_n_o,
	input  wire logic                       user_reset_i,
	output logic                            user_reset_o,
	output logic                            user_reset_oe_n_o,
	output logic                            link_up_o,
	// Analog resets
	output logic                            pll_reset_o,
	output logic                            phy_reset_o,
	// Serial lanes
	input  wire logic [lmr_pkg::LANES-1:0]  rx_serial_i,
	output logic      [lmr_pkg::LANES-1:0]  tx_serial_o
);
	// Busy indication carries no meaning here and is not looked at
	lmr_seq_if sq ();

	// =========================================================
	// Global reset sampling
	logic mrst_reg, mrst_next;
	always_comb begin
		mrst_next = mgmt_reset_i;
	end
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mrst_reg <= 1'b1;
		end else begin
			mrst_reg <= mrst_next;
		end
	end

	// =========================================================
	// Management port
	logic [lmr_pkg::DATA_W-1:0] rd_reg, rd_next;
	logic                       wait_reg, wait_next;
	logic [1:0]                 ctrl_reg, ctrl_next;
	logic [lmr_pkg::DATA_W-1:0] recfg_reg [lmr_pkg::LANES];
	logic [lmr_pkg::DATA_W-1:0] recfg_next [lmr_pkg::LANES];
	logic                       req, take, sel_recfg;
	logic [lmr_pkg::LANE_W-1:0] lane_idx;
	logic [lmr_pkg::ADDR_W-2:0] soft_addr;
	logic                       link_reg;

	function automatic logic [lmr_pkg::DATA_W-1:0] soft_read(
		input logic [lmr_pkg::ADDR_W-2:0] a,
		input logic [1:0]                 c,
		input logic                       dn,
		input logic                       lk,
		input logic                       pr,
		input logic                       hr
	);
		logic [lmr_pkg::DATA_W-1:0] v;
		v = 32'h0000_0000;
		if (a == lmr_pkg::CTRL_ADDR) begin
			v[1:0] = c;
		end else if (a == lmr_pkg::STATUS_ADDR) begin
			v[lmr_pkg::ST_DONE_BIT]    = dn;
			v[lmr_pkg::ST_LINK_BIT]    = lk;
			v[lmr_pkg::ST_PLL_RST_BIT] = pr;
			v[lmr_pkg::ST_PHY_RST_BIT] = hr;
		end
		return v;
	endfunction

	assign req       = mgmt_port_read_i | mgmt_port_write_i;
	assign take      = req & ~wait_reg;
	assign sel_recfg = mgmt_port_addr_i[lmr_pkg::ADDR_MSB];
	assign lane_idx  = mgmt_port_addr_i[lmr_pkg::LANE_W-1:0];
	assign soft_addr = mgmt_port_addr_i[lmr_pkg::ADDR_W-2:0];

	always_comb begin
		rd_next    = rd_reg;
		ctrl_next  = ctrl_reg;
		recfg_next = recfg_reg;
		// One wait cycle per access, then a single-cycle answer
		wait_next  = 1'b1;
		if (mrst_reg) begin
			ctrl_next = lmr_pkg::CTRL_RESET;
			rd_next   = 32'h0000_0000;
			for (int i = 0; i < lmr_pkg::LANES; i++) begin
				recfg_next[i] = lmr_pkg::RECFG_RESET;
			end
		end else if (req && wait_reg) begin
			wait_next = 1'b0;
			if (sel_recfg) begin
				rd_next = recfg_reg[lane_idx];
			end else begin
				rd_next = soft_read(soft_addr, ctrl_reg, sq.done, link_reg,
					sq.pll_reset, sq.phy_reset);
			end
		end else if (take && mgmt_port_write_i) begin
			if (sel_recfg) begin
				recfg_next[lane_idx] = mgmt_port_write_word_i;
			end else if (soft_addr == lmr_pkg::CTRL_ADDR) begin
				ctrl_next = mgmt_port_write_word_i[1:0];
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_reg   <= 32'h0000_0000;
			wait_reg <= 1'b1;
			ctrl_reg <= lmr_pkg::CTRL_RESET;
			for (int i = 0; i < lmr_pkg::LANES; i++) begin
				recfg_reg[i] <= lmr_pkg::RECFG_RESET;
			end
		end else begin
			rd_reg    <= rd_next;
			wait_reg  <= wait_next;
			ctrl_reg  <= ctrl_next;
			recfg_reg <= recfg_next;
		end
	end

	assign mgmt_port_read_word_o = rd_reg;
	assign mgmt_port_waitreq_o   = wait_reg;

	// =========================================================
	// Reset sequencer
	assign sq.restart  = mrst_reg | ctrl_reg[lmr_pkg::CTRL_PHY_RST_BIT];
	assign sq.std_mode = std_clk_mode_i;

	lmr_reset_seq u_seq (
		.mclk_i (mclk_i),
		.rstn_i (rstn_i),
		.sq     (sq)
	);

	assign pll_reset_o = sq.pll_reset;
	assign phy_reset_o = sq.phy_reset;

	// =========================================================
	// Link layer: async reset by core reset, leaves the PLL alone
	logic core_rstn;
	logic uclk_reg, uclk_next, uin_reg, uin_next, utick;
	logic urst_reg, urst_next, oen_reg, oen_next, link_next;
	logic [lmr_pkg::LANES-1:0] tx_reg, tx_next, seen_reg, seen_next, rx_lane;

	assign core_rstn = rstn_i & ~core_reset_i;
	// Core edge is one mclk edge after the divider toggles high
	assign utick = std_clk_mode_i ? (uclk_reg & ~uin_reg)
		: (user_clock_i & ~uin_reg);
	assign rx_lane = ctrl_reg[lmr_pkg::CTRL_LOOPBACK_BIT] ? tx_reg : rx_serial_i;

	always_comb begin
		uclk_next = ~uclk_reg;
		uin_next  = std_clk_mode_i ? uclk_reg : user_clock_i;
		oen_next  = ~std_clk_mode_i;
		urst_next = std_clk_mode_i ? ~sq.done : 1'b0;
		tx_next   = tx_reg;
		seen_next = seen_reg;
		link_next = link_reg;
		if (mrst_reg || !sq.done || (!std_clk_mode_i && user_reset_i)) begin
			// User reset in advanced mode flushes the source side
			tx_next   = '0;
			seen_next = '0;
			link_next = 1'b0;
		end else if (utick) begin
			tx_next   = ~tx_reg;
			seen_next = seen_reg | rx_lane;
			link_next = &seen_reg;
		end
	end

	always_ff @(posedge mclk_i or negedge core_rstn) begin
		if (!core_rstn) begin
			uclk_reg <= 1'b0;
			uin_reg  <= 1'b0;
			oen_reg  <= 1'b1;
			urst_reg <= 1'b1;
			tx_reg   <= '0;
			seen_reg <= '0;
			link_reg <= 1'b0;
		end else begin
			uclk_reg <= uclk_next;
			uin_reg  <= uin_next;
			oen_reg  <= oen_next;
			urst_reg <= urst_next;
			tx_reg   <= tx_next;
			seen_reg <= seen_next;
			link_reg <= link_next;
		end
	end

	assign user_clock_o      = uclk_reg;
	assign user_clock_oe_n_o = oen_reg;
	assign user_reset_o      = urst_reg;
	assign user_reset_oe_n_o = oen_reg;
	assign link_up_o         = link_reg;
	assign tx_serial_o       = tx_reg;

	// =========================================================
	// Checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);

	wait_one_a: assert property (req && wait_reg && !mrst_reg |=> !wait_reg)
		else $error("request not answered after one wait cycle");
	wait_pulse_a: assert property (!wait_reg |=> wait_reg)
		else $error("wait-request low for more than one cycle");
	write_ctrl_a: assert property (take && mgmt_port_write_i && !sel_recfg
		&& soft_addr == lmr_pkg::CTRL_ADDR && !mrst_reg
		|=> ctrl_reg == $past(mgmt_port_write_word_i[1:0]))
		else $error("control write lost");
	write_recfg_a: assert property (take && mgmt_port_write_i && sel_recfg
		&& !mrst_reg |=> recfg_reg[$past(lane_idx)]
		== $past(mgmt_port_write_word_i))
		else $error("reconfiguration write misrouted");
	read_ctrl_a: assert property (take && mgmt_port_read_i && !sel_recfg
		&& soft_addr == lmr_pkg::CTRL_ADDR && !$past(mrst_reg)
		|-> rd_reg == {30'h0, ctrl_reg})
		else $error("read data wrong in completing cycle");
	gbl_reset_a: assert property (mrst_reg && std_clk_mode_i
		|=> ##1 pll_reset_o && phy_reset_o && !link_up_o)
		else $error("global reset did not reset the core");
	core_reset_a: assert property (core_reset_i |-> user_reset_o
		&& !link_up_o)
		else $error("core reset did not hold user reset");
	link_rise_a: assert property ($rose(link_up_o) |-> $past(sq.done)
		&& $past(utick))
		else $error("link up before initialization");
	urst_rel_a: assert property ($fell(user_reset_o) && std_clk_mode_i
		|-> sq.done)
		else $error("user reset released early");

	read_cov: cover property (take && mgmt_port_read_i);
	write_cov: cover property (take && mgmt_port_write_i && sel_recfg);
	link_cov: cover property ($rose(link_up_o));
endmodule
`default_nettype wire

// ---- verification/lmr_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module lmr_host_model (
	// Clock
	input  wire logic                       mclk_i,
	// Management port
	input  wire logic                       waitreq_i,
	input  wire logic [lmr_pkg::DATA_W-1:0] read_word_i,
	output logic      [lmr_pkg::ADDR_W-1:0] addr_o,
	output logic      [lmr_pkg::DATA_W-1:0] write_word_o,
	output logic                            write_o,
	output logic                            read_o,
	output logic                            reconfig_busy_o,
	// User side
	input  wire logic                       user_mode_i,
	output logic                            user_clock_o,
	output logic                            user_reset_o,
	// Serial lanes
	input  wire logic [lmr_pkg::LANES-1:0]  tx_serial_i,
	output logic      [lmr_pkg::LANES-1:0]  rx_serial_o
);
	logic [1:0] div;

	initial begin
		addr_o = '0;
		write_word_o = '0;
		write_o = 1'h0;
		read_o = 1'h0;
		user_clock_o = 1'h0;
		user_reset_o = 1'h0;
		div = 2'h0;
	end

	assign reconfig_busy_o = 1'h0;
	assign rx_serial_o = tx_serial_i;

	// =====================
	// User clock, still while the core owns the pin
	always @(posedge mclk_i) begin
		#1;
		div = user_mode_i ? div + 2'h1 : 2'h0;
		user_clock_o = div[1];
	end

	task automatic user_reset(input logic v);
		user_reset_o = v;
	endtask

	// =====================
	// One access; q is unknown if the port never answers
	task automatic access(input logic wr,
		input logic [lmr_pkg::ADDR_W-1:0] a,
		input logic [lmr_pkg::DATA_W-1:0] d,
		output logic [lmr_pkg::DATA_W-1:0] q);
		int n;
		n = 0;
		q = 'x;
		@(posedge mclk_i);
		#1;
		addr_o = a;
		write_word_o = d;
		write_o = wr;
		read_o = !wr;
		do begin
			@(posedge mclk_i);
			n++;
		end while (waitreq_i !== 1'h0 && n < 64);
		if (waitreq_i === 1'h0) begin
			q = read_word_i;
		end
		#1;
		write_o = 1'h0;
		read_o = 1'h0;
		// Released lines must not keep looking valid
		addr_o = ~addr_o;
		write_word_o = ~write_word_o;
	endtask
endmodule
`default_nettype wire

// ---- verification/lmr_top_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module lmr_top_bench;
	logic                       mclk_i = 1'h0;
	logic                       rstn_i, mgmt_reset_i, core_reset_i;
	logic                       std_clk_mode_i, reconfig_busy_i;
	logic [lmr_pkg::ADDR_W-1:0] mgmt_port_addr_i;
	logic [lmr_pkg::DATA_W-1:0] mgmt_port_write_word_i;
	logic [lmr_pkg::DATA_W-1:0] mgmt_port_read_word_o;
	logic                       mgmt_port_write_i, mgmt_port_read_i;
	logic                       mgmt_port_waitreq_o, link_up_o;
	logic                       user_clock_o, user_clock_oe_n_o;
	logic                       user_reset_o, user_reset_oe_n_o;
	logic                       pll_reset_o, phy_reset_o;
	logic                       host_uclk, host_urst;
	logic [lmr_pkg::LANES-1:0]  rx_serial_i, tx_serial_o;
	wire logic                  user_clock_i, user_reset_i;
	int                         bad_count = 0;
	int                         cmp_count = 0;

	// Whoever holds the enable drives the two-way pin
	assign user_clock_i = user_clock_oe_n_o ? host_uclk : user_clock_o;
	assign user_reset_i = user_reset_oe_n_o ? host_urst : user_reset_o;

	lmr_top dut (
		.mclk_i, .rstn_i, .mgmt_reset_i, .core_reset_i, .std_clk_mode_i,
		.mgmt_port_addr_i, .mgmt_port_write_word_i, .mgmt_port_write_i,
		.mgmt_port_read_i, .reconfig_busy_i, .mgmt_port_read_word_o,
		.mgmt_port_waitreq_o, .user_clock_i, .user_clock_o,
		.user_clock_oe_n_o, .user_reset_i, .user_reset_o,
		.user_reset_oe_n_o, .link_up_o, .pll_reset_o, .phy_reset_o,
		.rx_serial_i, .tx_serial_o
	);
	lmr_host_model host (
		.mclk_i, .waitreq_i(mgmt_port_waitreq_o),
		.read_word_i(mgmt_port_read_word_o), .addr_o(mgmt_port_addr_i),
		.write_word_o(mgmt_port_write_word_i), .write_o(mgmt_port_write_i),
		.read_o(mgmt_port_read_i), .reconfig_busy_o(reconfig_busy_i),
		.user_mode_i(user_clock_oe_n_o), .user_clock_o(host_uclk),
		.user_reset_o(host_urst), .tx_serial_i(tx_serial_o),
		.rx_serial_o(rx_serial_i)
	);

	always #20 mclk_i = ~mclk_i;

	// =====================
	// Helpers
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic results();
		$display("Checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask

	task automatic wait_link(input int lim);
		int n;
		n = 0;
		while (link_up_o !== 1'h1 && n < lim) begin
			tick(1);
			n++;
		end
	endtask

	// =====================
	// Scenarios
	task automatic t_bring_up();
		int n;
		logic uc;
		logic [lmr_pkg::LANES-1:0] tx;
		check("rst wait", mgmt_port_waitreq_o, 1'h1);
		check("rst pll", pll_reset_o, 1'h1);
		check("rst user", user_reset_o, 1'h1);
		rstn_i = 1'h1;
		n = 0;
		while (pll_reset_o !== 1'h0 && n < 100) begin
			tick(1);
			n++;
		end
		check("pll span", n >= lmr_pkg::PLL_CYC &&
			n <= lmr_pkg::PLL_CYC + 3, 1'h1);
		check("phy after pll", phy_reset_o, 1'h1);
		n = 0;
		while (phy_reset_o !== 1'h0 && n < 100) begin
			tick(1);
			n++;
		end
		check("phy span", n + 1 >= lmr_pkg::PHY_CYC &&
			n <= lmr_pkg::PHY_CYC + 2, 1'h1);
		check("early link", link_up_o, 1'h0);
		wait_link(100);
		check("link up", link_up_o, 1'h1);
		check("user rel", user_reset_o, 1'h0);
		check("clk oe", user_clock_oe_n_o, 1'h0);
		uc = user_clock_o;
		tick(1);
		check("clk toggle", user_clock_o, !uc);
		tx = tx_serial_o;
		tick(2);
		check("tx toggle", tx_serial_o ^ tx, 4'hF);
	endtask

	task automatic t_registers();
		logic [31:0] q;
		check("addr w", $bits(mgmt_port_addr_i),
			10 + $clog2(lmr_pkg::LANES));
		check("lane w", $bits(tx_serial_o), lmr_pkg::LANES);
		host.access(1'h1, 12'h802, 32'hA5C3_0F96, q);
		host.access(1'h1, 12'h800, 32'hFFFF_FFFF, q);
		host.access(1'h1, 12'h000, 32'h0000_0002, q);
		host.access(1'h1, 12'h005, 32'h1234_5678, q);
		host.access(1'h0, 12'h802, 32'h0, q);
		check("rcfg 2", q, 32'hA5C3_0F96);
		host.access(1'h0, 12'h801, 32'h0, q);
		check("rcfg 1", q, 32'h0);
		host.access(1'h0, 12'h000, 32'h0, q);
		check("ctrl", q, 32'h0000_0002);
		host.access(1'h0, 12'h005, 32'h0, q);
		check("unmapped", q, 32'h0);
		host.access(1'h0, 12'h001, 32'h0, q);
		check("status", q, 32'h0000_0003);
		host.access(1'h1, 12'h000, 32'h0000_0001, q);
		tick(1);
		check("soft phy", phy_reset_o, 1'h1);
		check("soft pll", pll_reset_o, 1'h1);
		host.access(1'h1, 12'h000, 32'h0, q);
		wait_link(100);
		check("soft relink", link_up_o, 1'h1);
	endtask

	task automatic t_core_reset();
		logic [31:0] q;
		core_reset_i = 1'h1;
		#1;
		check("core user", user_reset_o, 1'h1);
		check("core link", link_up_o, 1'h0);
		tick(4);
		check("core pll", pll_reset_o, 1'h0);
		host.access(1'h0, 12'h802, 32'h0, q);
		check("core regs", q, 32'hA5C3_0F96);
		check("core hold", user_reset_o, 1'h1);
		core_reset_i = 1'h0;
		wait_link(100);
		check("core relink", link_up_o, 1'h1);
		check("core rel", user_reset_o, 1'h0);
	endtask

	task automatic t_mgmt_reset(input logic std);
		logic [31:0] q;
		mgmt_reset_i = 1'h1;
		core_reset_i = 1'h1;
		#1;
		check("sync rst", pll_reset_o, 1'h0);
		std_clk_mode_i = std;
		tick(40);
		check("rst wait", mgmt_port_waitreq_o, 1'h1);
		check("rst phy", phy_reset_o, 1'h1);
		check("rst link", link_up_o, 1'h0);
		if (std) begin
			check("rst pll", pll_reset_o, 1'h1);
			check("rst user", user_reset_o, 1'h1);
		end
		mgmt_reset_i = 1'h0;
		core_reset_i = 1'h0;
		tick(3);
		check("oe", user_clock_oe_n_o, !std);
		check("rst oe", user_reset_oe_n_o, !std);
		check("seq pll", pll_reset_o, std);
		wait_link(300);
		check("relink", link_up_o, 1'h1);
		host.access(1'h0, 12'h802, 32'h0, q);
		check("rcfg clr", q, lmr_pkg::RECFG_RESET);
	endtask

	task automatic t_user_reset();
		host.user_reset(1'h1);
		tick(12);
		check("adv rst", link_up_o, 1'h0);
		host.user_reset(1'h0);
		wait_link(200);
		check("adv relink", link_up_o, 1'h1);
	endtask

	// =====================
	// Sequence and watchdog
	initial begin
		rstn_i = 1'h0;
		mgmt_reset_i = 1'h0;
		core_reset_i = 1'h0;
		std_clk_mode_i = 1'h1;
		tick(5);
		t_bring_up();
		t_registers();
		t_core_reset();
		t_mgmt_reset(1'h1);
		t_mgmt_reset(1'h0);
		t_user_reset();
		results();
	end

	initial begin
		repeat (4000) @(posedge mclk_i);
		bad_count++;
		results();
	end
endmodule
`default_nettype wire
